// >>> hw/cfg_pkg.sv
// constants, types and states shared by the configuration control block
// assumes a single 100 MHz clock and a synchronous active-high reset
package cfg_pkg;

   // ----------------------------------------------------------------
   // clock and power-on delay timing
   // ----------------------------------------------------------------
   localparam int unsigned CLOCK_HZ       = 100_000_000;   // core clock rate
   localparam int unsigned POR_SHORT_MS   = 12;            // delay with select high
   localparam int unsigned POR_LONG_MS    = 100;           // delay with select low
   localparam int unsigned POR_SHORT_CYCLES = (CLOCK_HZ / 1000) * POR_SHORT_MS;
   localparam int unsigned POR_LONG_CYCLES  = (CLOCK_HZ / 1000) * POR_LONG_MS;

   // ----------------------------------------------------------------
   // delay counter
   // ----------------------------------------------------------------
   localparam int CNT_W = 24;                           // holds the long delay
   typedef logic [CNT_W-1:0] cnt_t;
   localparam cnt_t CNT_ZERO = 24'h000000;

   // ----------------------------------------------------------------
   // synchronised pin vector layout
   // ----------------------------------------------------------------
   localparam int SYNC_W        = 8;
   localparam int PIN_DELAY     = 0;                    // delay select
   localparam int PIN_PULLUP    = 1;                    // pull-up disable
   localparam int PIN_SCHEME_LO = 2;                    // scheme select, 3 bits
   localparam int PIN_NCONFIG   = 5;                    // config control, low active
   localparam int PIN_JTAG      = 6;                    // jtag programming active
   localparam int PIN_STATUS    = 7;                    // status wire level
   typedef logic [SYNC_W-1:0] pins_t;
   localparam pins_t PINS_RST   = 8'h00;

   // ----------------------------------------------------------------
   // reset values of latched configuration
   // ----------------------------------------------------------------
   localparam logic [2:0] SCHEME_RST  = 3'h0;
   localparam logic       POR_SEL_RST = 1'b0;           // long delay is the safe one
   localparam logic       PULLUP_RST  = 1'b0;

   // ----------------------------------------------------------------
   // controller states
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      S_SYNC_A,
      S_SYNC_B,
      S_SAMPLE,
      S_POR,
      S_WAIT,
      S_CONFIG,
      S_USER,
      S_ERROR,
      S_CLEAR
   } cfg_state_t;

endpackage

// >>> hw/por_timer_if.sv
// carrier between the controller and its power-on delay timer
// assumes both ends run on the same clock
`timescale 1ns/100ps
interface por_timer_if;
   logic start;      // one-cycle pulse, restarts the delay
   logic short_sel;  // high picks the short delay
   logic expired;    // level, high once the delay has run out

   modport ctrl  (output start, output short_sel, input expired);
   modport timer (input start, input short_sel, output expired);
endinterface

// >>> hw/por_timer.sv
// power-on delay timer: counts the selected delay after a start pulse
// assumes start comes from logic on the same clock
`timescale 1ns/100ps
module por_timer #(
   parameter int unsigned SHORT_CYCLES = cfg_pkg::POR_SHORT_CYCLES,
   parameter int unsigned LONG_CYCLES  = cfg_pkg::POR_LONG_CYCLES
) (
   input  wire logic     i_clock,
   input  wire logic     i_srst,
   por_timer_if.timer    tmr
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      cfg_pkg::cnt_t cnt;      // cycles still to run
      logic          expired;  // delay elapsed
   } tmr_state_t;

   tmr_state_t r;       // registered state
   tmr_state_t next_r;  // next state

   assign tmr.expired = r.expired;

   // count down; a new start always reloads, even mid-count
   always_comb
   begin
      next_r = r;
      if (tmr.start)
      begin
         // reload with the selected figure
         next_r.expired = 1'b0;
         next_r.cnt = tmr.short_sel ? cfg_pkg::cnt_t'(SHORT_CYCLES - 1)
                                    : cfg_pkg::cnt_t'(LONG_CYCLES - 1);
      end
      else if (r.cnt != cfg_pkg::CNT_ZERO)
      begin
         next_r.cnt = r.cnt - cfg_pkg::cnt_t'(1);
      end
      else
      begin
         next_r.expired = 1'b1;
      end
   end

   // register the state
   always_ff @(posedge i_clock)
   begin
      if (i_srst)
      begin
         r <= '{cnt: cfg_pkg::CNT_ZERO, expired: 1'b0};
      end
      else
      begin
         r <= next_r;
      end
   end

endmodule

// >>> hw/config_control.sv
// power-on reset and configuration control: latches straps, times the
// power-on delay, follows the config control input and the status wire
// assumes all pins are asynchronous; loader error/done are on I_CLOCK
`timescale 1ns/100ps

module config_control #(
   parameter int unsigned POR_SHORT_CYCLES = cfg_pkg::POR_SHORT_CYCLES,
   parameter int unsigned POR_LONG_CYCLES  = cfg_pkg::POR_LONG_CYCLES
) (
   input  wire logic       I_CLOCK,
   input  wire logic       I_SRST,
   input  wire logic       I_POR_DELAY_SELECT,   // strap
   input  wire logic       I_PULLUP_DISABLE,     // strap
   input  wire logic [2:0] I_SCHEME_SELECT,      // strap
   input  wire logic       I_CONFIG_CTRL_N,      // config control pin
   input  wire logic       I_JTAG_MODE,          // jtag programming active
   input  wire logic       I_CONFIG_STATUS_N_I,  // status wire level
   input  wire logic       I_CONFIG_ERROR,       // loader error pulse
   input  wire logic       I_CONFIG_DONE,        // loader finished pulse
   output logic            O_CONFIG_STATUS_N_O,  // status drive value
   output logic            O_CONFIG_STATUS_N_OE, // low while driving
   output logic [2:0]      O_SCHEME,             // latched scheme
   output logic            O_LOAD_START,         // start loader pulse
   output logic            O_CONFIG_CLEAR,       // configuration discarded
   output logic            O_IO_TRISTATE,        // all user io off
   output logic            O_WEAK_PULLUP_EN,     // weak pull-ups on
   output logic            O_USER_MODE,          // configured
   output logic            O_ERROR               // error state
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      cfg_pkg::cfg_state_t state;       // controller state
      cfg_pkg::pins_t      sync1;       // first sync stage, read by sync2 only
      cfg_pkg::pins_t      sync2;       // synchronised pins
      logic                por_pending; // power-on delay still owed
      logic                por_sel;     // latched delay select
      logic                pullup_dis;  // latched pull-up disable
      logic [2:0]          scheme;      // latched scheme select
      logic                timer_start; // timer start pulse
      logic                drive_low;   // pulling the status wire
      logic                load_start;  // loader start pulse
      logic                clear;       // configuration clear
      logic                tristate;    // io off
      logic                pullup_en;   // weak pull-ups on
      logic                user;        // user mode
      logic                err;         // error state
   } ctl_state_t;

   ctl_state_t     r;         // registered state
   ctl_state_t     next_r;    // next state
   cfg_pkg::pins_t pins;      // raw pin vector
   logic           cfg_high;  // control high, or ignored
   logic           status_s;  // synchronised status wire
   logic           jtag_s;    // synchronised jtag mode

   por_timer_if tmr ();

   assign pins = {I_CONFIG_STATUS_N_I, I_JTAG_MODE, I_CONFIG_CTRL_N,
                  I_SCHEME_SELECT, I_PULLUP_DISABLE, I_POR_DELAY_SELECT};
   assign jtag_s   = r.sync2[cfg_pkg::PIN_JTAG];
   assign status_s = r.sync2[cfg_pkg::PIN_STATUS];
   // jtag programming treats the control input as high
   assign cfg_high = jtag_s | r.sync2[cfg_pkg::PIN_NCONFIG];

   assign tmr.start     = r.timer_start;
   assign tmr.short_sel = r.por_sel;

   // ----------------------------------------------------------------
   // power-on delay timer
   // ----------------------------------------------------------------
   por_timer #(
      .SHORT_CYCLES (POR_SHORT_CYCLES),
      .LONG_CYCLES  (POR_LONG_CYCLES)
   ) u_timer (
      .i_clock (I_CLOCK),
      .i_srst  (I_SRST),
      .tmr     (tmr)
   );

   // ----------------------------------------------------------------
   // next-state logic
   // ----------------------------------------------------------------
   // the straps are only looked at in S_SAMPLE, so a strap that moves
   // later has no effect until the next cycle start
   always_comb
   begin
      next_r             = r;
      next_r.sync1       = pins;
      next_r.sync2       = r.sync1;
      next_r.timer_start = 1'b0;
      next_r.load_start  = 1'b0;
      case (r.state)
         // two cycles let the synchronisers fill after reset
         cfg_pkg::S_SYNC_A: next_r.state = cfg_pkg::S_SYNC_B;
         cfg_pkg::S_SYNC_B: next_r.state = cfg_pkg::S_SAMPLE;
         cfg_pkg::S_SAMPLE:
         begin
            // catch the straps once per cycle
            next_r.por_sel    = r.sync2[cfg_pkg::PIN_DELAY];
            next_r.pullup_dis = r.sync2[cfg_pkg::PIN_PULLUP];
            next_r.scheme     = r.sync2[cfg_pkg::PIN_SCHEME_LO +: 3];
            if (r.por_pending)
            begin
               next_r.timer_start = 1'b1;
               next_r.state       = cfg_pkg::S_POR;
            end
            else
            begin
               next_r.state = cfg_pkg::S_WAIT;
            end
         end
         cfg_pkg::S_POR:
         begin
            // hold status low until the delay is over
            if (tmr.expired && !r.timer_start)
            begin
               next_r.por_pending = 1'b0;
               next_r.state       = cfg_pkg::S_WAIT;
            end
         end
         cfg_pkg::S_WAIT:
         begin
            // a status wire still held low from outside also blocks the start
            if (!cfg_high)
            begin
               next_r.state = cfg_pkg::S_CLEAR;
            end
            else if (status_s)
            begin
               next_r.load_start = 1'b1;
               next_r.state      = cfg_pkg::S_CONFIG;
            end
         end
         cfg_pkg::S_CONFIG:
         begin
            if (!cfg_high)
            begin
               next_r.state = cfg_pkg::S_CLEAR;
            end
            else if (I_CONFIG_ERROR || !status_s)
            begin
               next_r.state = cfg_pkg::S_ERROR;
            end
            else if (I_CONFIG_DONE)
            begin
               next_r.state = cfg_pkg::S_USER;
            end
         end
         cfg_pkg::S_USER:
         begin
            if (!cfg_high)
            begin
               next_r.state = cfg_pkg::S_CLEAR;
            end
         end
         cfg_pkg::S_ERROR:
         begin
            // only a pulse on the control input leaves the error state
            if (!cfg_high)
            begin
               next_r.state = cfg_pkg::S_CLEAR;
            end
         end
         cfg_pkg::S_CLEAR:
         begin
            if (cfg_high)
            begin
               next_r.state = cfg_pkg::S_SAMPLE;
            end
         end
         default: next_r.state = cfg_pkg::S_SYNC_A;
      endcase
      // outputs follow the next state so they leave as flops
      next_r.drive_low = (next_r.state != cfg_pkg::S_WAIT) &&
                         (next_r.state != cfg_pkg::S_CONFIG) &&
                         (next_r.state != cfg_pkg::S_USER);
      next_r.clear     = (next_r.state == cfg_pkg::S_CLEAR);
      next_r.tristate  = (next_r.state != cfg_pkg::S_USER);
      next_r.user      = (next_r.state == cfg_pkg::S_USER);
      next_r.err       = (next_r.state == cfg_pkg::S_ERROR);
      next_r.pullup_en = (next_r.state != cfg_pkg::S_USER) && !next_r.pullup_dis;
   end

   // register the state
   always_ff @(posedge I_CLOCK)
   begin
      if (I_SRST)
      begin
         r <= '{state: cfg_pkg::S_SYNC_A, sync1: cfg_pkg::PINS_RST,
                sync2: cfg_pkg::PINS_RST, por_pending: 1'b1,
                por_sel: cfg_pkg::POR_SEL_RST, pullup_dis: cfg_pkg::PULLUP_RST,
                scheme: cfg_pkg::SCHEME_RST, timer_start: 1'b0, drive_low: 1'b1,
                load_start: 1'b0, clear: 1'b0, tristate: 1'b1, pullup_en: 1'b1,
                user: 1'b0, err: 1'b0};
      end
      else
      begin
         r <= next_r;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign O_CONFIG_STATUS_N_O  = ~r.drive_low;
   assign O_CONFIG_STATUS_N_OE = ~r.drive_low;
   assign O_SCHEME             = r.scheme;
   assign O_LOAD_START         = r.load_start;
   assign O_CONFIG_CLEAR       = r.clear;
   assign O_IO_TRISTATE        = r.tristate;
   assign O_WEAK_PULLUP_EN     = r.pullup_en;
   assign O_USER_MODE          = r.user;
   assign O_ERROR              = r.err;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge I_CLOCK); endclocking
   default disable iff (I_SRST);

   AST_POR_SELECT: assert property (
      (r.state == cfg_pkg::S_SAMPLE && r.por_pending)
      |=> (tmr.start && tmr.short_sel == $past(r.sync2[cfg_pkg::PIN_DELAY])))
      else $error("delay select not passed to timer");
   AST_PULLUP: assert property (
      (r.state == cfg_pkg::S_SAMPLE)
      |=> (O_WEAK_PULLUP_EN == !$past(r.sync2[cfg_pkg::PIN_PULLUP])))
      else $error("pull-up enable does not follow its strap");
   AST_STRAP_HOLD: assert property (
      (r.state != cfg_pkg::S_SAMPLE)
      |=> ($stable(O_SCHEME) && $stable(r.por_sel) && $stable(r.pullup_dis)))
      else $error("strap changed outside sampling");
   AST_USER_CLEAR: assert property (
      (r.state == cfg_pkg::S_USER && !cfg_high)
      |=> (O_CONFIG_CLEAR && O_IO_TRISTATE && !O_USER_MODE))
      else $error("control low in user mode not cleared");
   AST_RECONFIG: assert property (
      (r.state == cfg_pkg::S_CLEAR && cfg_high) |=> r.state == cfg_pkg::S_SAMPLE
      ##1 r.state == cfg_pkg::S_WAIT)
      else $error("no new cycle after control rise");
   AST_START_HIGH: assert property (
      O_LOAD_START |-> ($past(cfg_high) && $past(r.state) == cfg_pkg::S_WAIT))
      else $error("loader started without control high");
   AST_JTAG_IGNORE: assert property (
      (jtag_s && r.state == cfg_pkg::S_USER) |=> O_USER_MODE)
      else $error("jtag mode left user mode");
   AST_POR_STATUS: assert property (
      (r.state == cfg_pkg::S_POR) |-> !O_CONFIG_STATUS_N_OE)
      else $error("status released during power-on delay");
   AST_ERR_DRIVE: assert property (
      (r.state == cfg_pkg::S_CONFIG && cfg_high && I_CONFIG_ERROR)
      |=> (O_ERROR && !O_CONFIG_STATUS_N_OE) ##1 !O_CONFIG_STATUS_N_OE)
      else $error("error not shown on status wire");
   AST_EXT_ERR: assert property (
      (r.state == cfg_pkg::S_CONFIG && cfg_high && !status_s) |=> O_ERROR)
      else $error("external status low ignored");
   AST_WAIT_HIGH: assert property (
      (r.state == cfg_pkg::S_WAIT && !cfg_high) |=> !O_LOAD_START)
      else $error("start while control low after delay");

   COV_USER:   cover property (r.state == cfg_pkg::S_CONFIG ##1 r.state == cfg_pkg::S_USER);
   COV_ERROR:  cover property (r.state == cfg_pkg::S_CONFIG ##1 r.state == cfg_pkg::S_ERROR);
   COV_RECONF: cover property (r.state == cfg_pkg::S_USER ##1 r.state == cfg_pkg::S_CLEAR);
   COV_JTAG:   cover property (jtag_s && !r.sync2[cfg_pkg::PIN_NCONFIG] && O_USER_MODE);

endmodule

// >>> verif/cfg_host_model.sv
// model of the board and configuration host around the config control block
// assumes the bench commands it at rising clock edges; one clock, no reset
`timescale 1ns/100ps
module cfg_host_model (
   input  wire logic       i_clock,       // core clock
   input  wire logic       i_supply_ok,   // all supplies settled
   input  wire logic       i_ctrl_req_n,  // host wants control low
   input  wire logic       i_strap_load,  // board is (re)strapped this cycle
   input  wire logic [4:0] i_strap,       // {scheme, pull-up disable, delay}
   input  wire logic       i_ext_low,     // host pulls status wire low
   input  wire logic       i_status_o,    // device status drive value
   input  wire logic       i_status_oe_n, // device status enable, low drives
   output logic            o_delay_sel,   // delay select strap pin
   output logic            o_pullup_dis,  // pull-up disable strap pin
   output logic [2:0]      o_scheme,      // scheme select strap pins
   output logic            o_ctrl_n,      // config control pin
   output logic            o_status       // resolved status wire
);
   // ----------------------------------------------------------------
   // straps
   // ----------------------------------------------------------------
   logic [4:0] strap; // strap levels as wired on the board, loaded while the bench strobes

   // straps only move when the board is re-strapped on command
   always_ff @(posedge i_clock)
   begin
      if (i_strap_load)
      begin
         strap <= i_strap;
      end
   end
   assign o_delay_sel  = strap[0];
   assign o_pullup_dis = strap[1];
   assign o_scheme     = strap[4:2];

   // ----------------------------------------------------------------
   // control and status wire
   // ----------------------------------------------------------------
   // control held low until the supplies settle, whatever the host asks
   assign o_ctrl_n = i_ctrl_req_n & i_supply_ok;
   // open-drain wire with pull-up: low if either party pulls it
   assign o_status = (!i_status_oe_n) ? i_status_o : !i_ext_low;
endmodule

// >>> verif/config_control_bench.sv
// self-checking bench for the config control block
// assumes short power-on counts; drives the strap, control and status pins through the host model
`timescale 1ns/100ps
`define CHK(got, exp) \
   begin \
      comparisons++; \
      if ((got) !== (exp)) \
      begin \
         num_errors++; \
         $display("mismatch at %0t: got %0h expected %0h", $time, got, exp); \
      end \
   end
module config_control_bench;
   // ----------------------------------------------------------------
   // settings and table
   // ----------------------------------------------------------------
   localparam int SHORT_N = 8;  // shortened delay, select high
   localparam int LONG_N  = 20; // shortened delay, select low
   typedef struct packed {logic dsel; logic pdis; logic [2:0] sch; logic pu;} row_t;
   // straps beside the pull-up enable they should give; every scheme once
   row_t rows [8] = '{
      '{1'h0, 1'h0, 3'h0, 1'h1}, '{1'h1, 1'h1, 3'h1, 1'h0},
      '{1'h0, 1'h1, 3'h2, 1'h0}, '{1'h1, 1'h0, 3'h3, 1'h1},
      '{1'h0, 1'h0, 3'h4, 1'h1}, '{1'h1, 1'h1, 3'h5, 1'h0},
      '{1'h1, 1'h0, 3'h6, 1'h1}, '{1'h0, 1'h1, 3'h7, 1'h0}};
   int num_errors  = 0; // mismatches so far
   int comparisons = 0; // checks so far
   logic       clock = 1'h0, srst = 1'h1, supply_ok = 1'h1, ctrl_req_n = 1'h1;
   logic       strap_load = 1'h1, ext_low = 1'h0, jtag = 1'h0;
   logic       cfg_err = 1'h0, cfg_done = 1'h0;
   logic [4:0] strap = 5'h00;
   logic       dsel, pdis, ctrl_n, status, status_o, status_oe_n;
   logic       load_start, clear, tristate, pu_en, user_mode, error;
   logic [2:0] sch_pin, scheme;

   // 100 MHz clock
   always #5 clock = ~clock;

   // ----------------------------------------------------------------
   // instances
   // ----------------------------------------------------------------
   cfg_host_model cfg_host_model_inst (
      .i_clock(clock), .i_supply_ok(supply_ok), .i_ctrl_req_n(ctrl_req_n),
      .i_strap_load(strap_load), .i_strap(strap), .i_ext_low(ext_low),
      .i_status_o(status_o), .i_status_oe_n(status_oe_n), .o_delay_sel(dsel),
      .o_pullup_dis(pdis), .o_scheme(sch_pin), .o_ctrl_n(ctrl_n), .o_status(status));
   config_control #(.POR_SHORT_CYCLES(SHORT_N), .POR_LONG_CYCLES(LONG_N)) config_control_inst (
      .I_CLOCK(clock), .I_SRST(srst), .I_POR_DELAY_SELECT(dsel),
      .I_PULLUP_DISABLE(pdis), .I_SCHEME_SELECT(sch_pin), .I_CONFIG_CTRL_N(ctrl_n),
      .I_JTAG_MODE(jtag), .I_CONFIG_STATUS_N_I(status), .I_CONFIG_ERROR(cfg_err),
      .I_CONFIG_DONE(cfg_done), .O_CONFIG_STATUS_N_O(status_o),
      .O_CONFIG_STATUS_N_OE(status_oe_n), .O_SCHEME(scheme), .O_LOAD_START(load_start),
      .O_CONFIG_CLEAR(clear), .O_IO_TRISTATE(tristate), .O_WEAK_PULLUP_EN(pu_en),
      .O_USER_MODE(user_mode), .O_ERROR(error));

   // ----------------------------------------------------------------
   // tasks
   // ----------------------------------------------------------------
   // verdict and end of run, shared with the watchdog
   task automatic final_report;
      if (num_errors == 0 && comparisons > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // waits, bounded, for a chosen output to reach a level; sampled 1 ns after edges
   task automatic wait_for(input int sel, input logic val, input int max, output int n);
      logic s;
      n = 0;
      s = ~val;
      while (s !== val && n < max)
      begin
         @(posedge clock);
         #1;
         n++;
         case (sel)
            0: s = status_oe_n;
            1: s = load_start;
            2: s = user_mode;
            3: s = error;
            default: s = clear;
         endcase
      end
      if (s !== val)
      begin
         num_errors++;
         $display("mismatch at %0t: wait ran out", $time);
      end
   endtask

   // resets with new straps; reset values are checked before release
   task automatic boot(input row_t r, input logic sup);
      @(posedge clock);
      srst       <= 1'h1;
      supply_ok  <= sup;
      strap_load <= 1'h1;
      strap      <= {r.sch, r.pdis, r.dsel};
      repeat (5) @(posedge clock);
      #1;
      `CHK(status_oe_n, 1'h0)
      `CHK(status_o, 1'h0)
      `CHK(tristate, 1'h1)
      @(posedge clock);
      srst       <= 1'h0;
      strap_load <= 1'h0;
   endtask

   // ----------------------------------------------------------------
   // watchdog: the whole run is a few hundred cycles
   // ----------------------------------------------------------------
   initial
   begin
      repeat (20000) @(posedge clock);
      num_errors++;
      final_report();
   end

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial
   begin
      int n, exp_n;
      logic seen;
      // table: power-on with each strap set, then load and enter user mode
      foreach (rows[i])
      begin
         boot(rows[i], 1'h1);
         exp_n = rows[i].dsel ? SHORT_N : LONG_N;
         wait_for(0, 1'h1, 60, n);
         `CHK(n >= exp_n + 2 && n <= exp_n + 8, 1'h1)
         `CHK(scheme, rows[i].sch)
         `CHK(pu_en, rows[i].pu)
         wait_for(1, 1'h1, 10, n);
         `CHK(load_start, 1'h1)
         // the board moves its straps mid-cycle; the latched ones must hold
         @(posedge clock);
         strap_load <= 1'h1;
         strap      <= ~{rows[i].sch, rows[i].pdis, rows[i].dsel};
         cfg_done   <= 1'h1;
         @(posedge clock);
         strap_load <= 1'h0;
         cfg_done   <= 1'h0;
         wait_for(2, 1'h1, 5, n);
         `CHK(tristate, 1'h0)
         `CHK(scheme, rows[i].sch)
         // weak pull-ups only matter before and during configuration
         `CHK(pu_en, 1'h0)
      end
      // jtag mode: control low must leave user mode alone
      @(posedge clock);
      jtag       <= 1'h1;
      ctrl_req_n <= 1'h0;
      repeat (8) @(posedge clock);
      #1;
      `CHK(user_mode, 1'h1)
      // control low seen: cleared, tri-stated, status pulled
      @(posedge clock);
      jtag <= 1'h0;
      wait_for(4, 1'h1, 8, n);
      `CHK(tristate, 1'h1)
      `CHK(user_mode, 1'h0)
      `CHK(status_oe_n, 1'h0)
      // no start while control stays low
      seen = 1'h0;
      repeat (12)
      begin
         @(posedge clock);
         #1;
         seen = seen | load_start;
      end
      `CHK(seen, 1'h0)
      // rising control restarts without the power-on delay
      @(posedge clock);
      ctrl_req_n <= 1'h1;
      wait_for(1, 1'h1, 15, n);
      `CHK(load_start, 1'h1)
      // outside party pulls status low during configuration
      @(posedge clock);
      ext_low <= 1'h1;
      wait_for(3, 1'h1, 8, n);
      `CHK(status_oe_n, 1'h0)
      @(posedge clock);
      ext_low <= 1'h0;
      repeat (5) @(posedge clock);
      #1;
      `CHK(error, 1'h1)
      // control pulse leaves error, then a loader error is reported
      @(posedge clock);
      ctrl_req_n <= 1'h0;
      repeat (4) @(posedge clock);
      ctrl_req_n <= 1'h1;
      wait_for(1, 1'h1, 15, n);
      `CHK(error, 1'h0)
      @(posedge clock);
      cfg_err <= 1'h1;
      @(posedge clock);
      cfg_err <= 1'h0;
      wait_for(3, 1'h1, 6, n);
      `CHK(status_oe_n, 1'h0)
      // supplies slow: control held low past the delay, no start until they settle
      boot(rows[0], 1'h0);
      seen = 1'h0;
      repeat (LONG_N + 20)
      begin
         @(posedge clock);
         #1;
         seen = seen | load_start;
      end
      `CHK(seen, 1'h0)
      @(posedge clock);
      supply_ok <= 1'h1;
      wait_for(1, 1'h1, 15, n);
      `CHK(load_start, 1'h1)
      final_report();
   end
endmodule
